// >>> shrc_pkg.sv
// Package: constants, states and carrier types of the stop/halt recovery control
package shrc_pkg;
    localparam int unsigned SHRC_NPINS = 60;
    localparam int unsigned SHRC_PORT8_CNT = 7;
    localparam int unsigned SHRC_PORT4_W = 4;
    localparam logic [6:0] SHRC_RC_CYC = 7'h42;
    localparam logic [4:0] SHRC_SYS_CYC = 5'h10;
    localparam int unsigned SHRC_CLK_PS = 4000;
    localparam int unsigned SHRC_GLITCH_PS = 10000;
    localparam int unsigned SHRC_FILT_INT =
        (SHRC_GLITCH_PS + SHRC_CLK_PS - 1) / SHRC_CLK_PS;
    localparam logic [1:0] SHRC_FILT_CYC = SHRC_FILT_INT[1:0];
    localparam logic [15:0] SHRC_VEC_LO = 16'h0002;
    localparam logic [15:0] SHRC_VEC_HI = 16'h0003;
    localparam logic [2:0] SHRC_A_CTRL = 3'h0;
    localparam logic [2:0] SHRC_A_WDTCTL = 3'h1;
    localparam logic [2:0] SHRC_A_SMRE_LO = 3'h2;
    localparam logic [2:0] SHRC_A_SMRE_HI = 3'h3;
    localparam logic [2:0] SHRC_A_PIN_LO = 3'h4;
    localparam logic [2:0] SHRC_A_PIN_HI = 3'h5;
    localparam int unsigned SHRC_B_WDT_EN = 0;
    localparam int unsigned SHRC_B_WDT_STOP = 1;
    localparam int unsigned SHRC_B_WDT_IRQ = 2;
    localparam int unsigned SHRC_B_BOR_STOP = 3;
    localparam int unsigned SHRC_B_STOPF = 0;
    localparam int unsigned SHRC_B_WDTF = 1;
    localparam int unsigned SHRC_B_PORF = 2;
    localparam int unsigned SHRC_B_EXTF = 3;
    localparam logic [3:0] SHRC_CTRL_RST = 4'h0;
    localparam logic [31:0] SHRC_SMRE_RST = 32'h0000_0000;

    typedef enum logic [2:0] {
        SHRC_RUN, SHRC_HALT, SHRC_STOP, SHRC_REC_RC, SHRC_REC_SYS
    } shrc_state_t;

    typedef struct packed {
        logic stop_exec;
        logic halt_exec;
        logic any_irq;
        logic wdt_timeout;
        logic por_bor;
        logic ext_reset;
        logic wdt_rc_tick;
        logic irq_enable;
        logic wdt_irq_ack;
    } shrc_evt_t;

    typedef struct packed {
        logic osc_en;
        logic sys_clk_en;
        logic core_run;
        logic core_rst;
        logic full_rst;
        logic wdt_rc_en;
        logic wdt_run;
        logic bor_en;
        logic periph_idle;
    } shrc_pwr_t;
endpackage

// >>> shrc_top.sv
// Stop and halt mode control with recovery sequencing and wake filtering
//
// Implementation choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
// Operation
// - Stop instruction from the core puts the device into stop mode.
// - Recovery holds reset 66 RC ticks, then 16 system clocks.
// - Recovery touches only watchdog control; other state kept.
// - After recovery the core loads the vector at 0002h/0003h.
// - Every recovery from stop sets the stop flag; a full reset clears it.
// - Watchdog timeout in stop recovers and sets watchdog and stop flags.
// - Watchdog in interrupt mode recovers, then interrupt served if enabled.
// - Each pin selectable as wake source; any edge on enabled pin wakes.
// - Wake path rejects pulses shorter than about 10 ns.
// - Input data registers frozen in stop; resample after recovery delay.
// - Stop halts oscillator, drives XIN high, XOUT low, stops clock and core.
// - Watchdog and RC oscillator run in stop only if enabled for it.
// - Brown-out detector active in stop only if its option enables it.
// - Other peripherals idle during stop.
// - Halt stops the core while oscillator and system clock keep running.
// - Halt keeps RC oscillator, watchdog if enabled, and peripherals running.
// - Halt exits on interrupt, watchdog timeout, POR/BOR or external reset.
// - Seven 8-bit ports and one 4-bit port, each pin individual.
// - POR/BOR beats every other source and gives a full system reset.
module shrc_top
    import shrc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [2:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire shrc_evt_t evt,
    input wire logic [SHRC_NPINS-1:0] gpio_in,
    output logic [SHRC_NPINS-1:0] port_input_data_reg,
    output logic pin_change,
    output shrc_pwr_t pwr,
    output logic xin_o,
    output logic xin_oe_b,
    output logic xout_o,
    output logic xout_oe_b,
    output logic vector_fetch,
    output logic [15:0] vector_addr_lo,
    output logic [15:0] vector_addr_hi,
    output logic wdt_irq_req,
    output shrc_state_t mode
);
    shrc_state_t state_r;
    logic [6:0] rc_cnt_r;
    logic [4:0] sys_cnt_r;
    logic [3:0] ctrl_r;
    logic [31:0] smre_lo_r;
    logic [27:0] smre_hi_r;
    logic stopf_r, wdtf_r, porf_r, extf_r;
    logic full_r;
    logic wdt_pend_r;
    logic ack_r;
    logic vec_r;
    logic [SHRC_NPINS-1:0] filt_r;
    logic [SHRC_NPINS-1:0] ref_r;
    logic [SHRC_NPINS-1:0] smre;
    logic [SHRC_NPINS-1:0] pin_nxt;
    logic gpio_wake, wdt_live, wdt_wake, go_full, rec_done;
    logic wr_hit, rd_hit, clr_stop, clr_wdt, clr_por, clr_ext;

    assign smre = {smre_hi_r, smre_lo_r};

    // Filter per pin: a change must stand SHRC_FILT_CYC clocks
    genvar gi;
    generate
        for (gi = 0; gi < SHRC_NPINS; gi++) begin : g_filt
            logic [1:0] cnt_r;
            always_ff @(posedge core_clk or negedge rst_b) begin
                if (!rst_b) begin
                    cnt_r <= 2'h0;
                    filt_r[gi] <= 1'b0;
                end else if (gpio_in[gi] == filt_r[gi]) begin
                    cnt_r <= 2'h0;
                end else if (cnt_r == SHRC_FILT_CYC - 2'h1) begin
                    cnt_r <= 2'h0;
                    filt_r[gi] <= gpio_in[gi];
                end else begin
                    cnt_r <= cnt_r + 2'h1;
                end
            end
        end
    endgenerate

    assign wdt_live = ctrl_r[SHRC_B_WDT_EN] &
        ((state_r != SHRC_STOP) | ctrl_r[SHRC_B_WDT_STOP]);
    assign wdt_wake = (state_r == SHRC_STOP) & evt.wdt_timeout &
        wdt_live;
    assign gpio_wake = (state_r == SHRC_STOP) &
        (|((filt_r ^ ref_r) & smre));
    // Watchdog in reset mode in run or halt is a full system reset
    assign go_full = evt.por_bor | evt.ext_reset |
        (evt.wdt_timeout & wdt_live & ~ctrl_r[SHRC_B_WDT_IRQ] &
         (state_r == SHRC_RUN || state_r == SHRC_HALT));
    assign rec_done = (state_r == SHRC_REC_SYS) &
        (sys_cnt_r == SHRC_SYS_CYC - 5'h1);

    // Full reset outranks every mode change

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= SHRC_REC_RC;
        end else if (go_full) begin
            state_r <= SHRC_REC_RC;
        end else begin
            unique case (state_r)
                SHRC_RUN: begin
                    if (evt.stop_exec) begin
                        state_r <= SHRC_STOP;
                    end else if (evt.halt_exec) begin
                        state_r <= SHRC_HALT;
                    end
                end
                SHRC_HALT: begin
                    if (evt.any_irq | (evt.wdt_timeout & wdt_live)) begin
                        state_r <= SHRC_RUN;
                    end
                end
                SHRC_STOP: begin
                    if (wdt_wake | gpio_wake) begin
                        state_r <= SHRC_REC_RC;
                    end
                end
                SHRC_REC_RC: begin
                    if (evt.wdt_rc_tick && rc_cnt_r == SHRC_RC_CYC - 7'h1) begin
                        state_r <= SHRC_REC_SYS;
                    end
                end
                SHRC_REC_SYS: begin
                    if (rec_done) begin
                        state_r <= SHRC_RUN;
                    end
                end
            endcase
        end
    end

    // Two counters in sequence: RC ticks, then system clocks
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rc_cnt_r <= 7'h00;
            sys_cnt_r <= 5'h00;
        end else if (go_full || state_r != SHRC_REC_RC &&
                     state_r != SHRC_REC_SYS) begin
            rc_cnt_r <= 7'h00;
            sys_cnt_r <= 5'h00;
        end else if (state_r == SHRC_REC_RC) begin
            if (evt.wdt_rc_tick) begin
                rc_cnt_r <= rc_cnt_r + 7'h01;
            end
        end else begin
            sys_cnt_r <= sys_cnt_r + 5'h01;
        end
    end

    // Remembers whether the pending recovery is a full system reset
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            full_r <= 1'b1;
        end else if (go_full) begin
            full_r <= 1'b1;
        end else if (state_r == SHRC_STOP) begin
            full_r <= 1'b0;
        end
    end

    // Wake reference is the filtered level seen when stop begins
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ref_r <= '0;
        end else if (state_r != SHRC_STOP) begin
            ref_r <= filt_r;
        end
    end

    // Input data frozen through stop and the recovery delay
    assign pin_nxt = gpio_in;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            port_input_data_reg <= '0;
            pin_change <= 1'b0;
        end else if (state_r == SHRC_RUN || state_r == SHRC_HALT) begin
            port_input_data_reg <= pin_nxt;
            pin_change <= |(pin_nxt ^ port_input_data_reg);
        end else begin
            pin_change <= 1'b0;
        end
    end

    // Avalon slave: one wait cycle on every access
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
    assign wr_hit = avs_write & ack_r;
    assign rd_hit = avs_read & ~ack_r;
    assign clr_stop = wr_hit && avs_address == SHRC_A_WDTCTL &&
        avs_writedata[SHRC_B_STOPF];
    assign clr_wdt = wr_hit && avs_address == SHRC_A_WDTCTL &&
        avs_writedata[SHRC_B_WDTF];
    assign clr_por = wr_hit && avs_address == SHRC_A_WDTCTL &&
        avs_writedata[SHRC_B_PORF];
    assign clr_ext = wr_hit && avs_address == SHRC_A_WDTCTL &&
        avs_writedata[SHRC_B_EXTF];

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (avs_read | avs_write) & ~ack_r;
        end
    end

    // Loaded in the wait cycle so data stand when waitrequest drops
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            avs_readdata <= 32'h0000_0000;
        end else if (rd_hit) begin
            unique case (avs_address)
                SHRC_A_CTRL: avs_readdata <= {28'h0, ctrl_r};
                SHRC_A_WDTCTL: avs_readdata <= {25'h0, state_r,
                    extf_r, porf_r, wdtf_r, stopf_r};
                SHRC_A_SMRE_LO: avs_readdata <= smre_lo_r;
                SHRC_A_SMRE_HI: avs_readdata <= {4'h0, smre_hi_r};
                SHRC_A_PIN_LO: avs_readdata <= port_input_data_reg[31:0];
                SHRC_A_PIN_HI: avs_readdata <= {4'h0,
                    port_input_data_reg[SHRC_NPINS-1:32]};
                default: avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // Configuration survives recovery, reset only by a full reset
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_r <= SHRC_CTRL_RST;
            smre_lo_r <= SHRC_SMRE_RST;
            smre_hi_r <= SHRC_SMRE_RST[27:0];
        end else if (pwr.full_rst) begin
            ctrl_r <= SHRC_CTRL_RST;
            smre_lo_r <= SHRC_SMRE_RST;
            smre_hi_r <= SHRC_SMRE_RST[27:0];
        end else if (wr_hit) begin
            if (avs_address == SHRC_A_CTRL) begin
                ctrl_r <= avs_writedata[3:0];
            end
            if (avs_address == SHRC_A_SMRE_LO) begin
                smre_lo_r <= avs_writedata;
            end
            if (avs_address == SHRC_A_SMRE_HI) begin
                smre_hi_r <= avs_writedata[27:0];
            end
        end
    end

    // Cause flags: a hardware set wins over a software clear
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            stopf_r <= 1'b0;
            wdtf_r <= 1'b0;
            porf_r <= 1'b1;
            extf_r <= 1'b0;
        end else if (go_full) begin
            stopf_r <= 1'b0;
            wdtf_r <= ~evt.por_bor & ~evt.ext_reset;
            porf_r <= evt.por_bor;
            extf_r <= ~evt.por_bor & evt.ext_reset;
        end else begin
            if (wdt_wake | gpio_wake) begin
                stopf_r <= 1'b1;
            end else if (clr_stop) begin
                stopf_r <= 1'b0;
            end
            if (wdt_wake) begin
                wdtf_r <= 1'b1;
            end else if (clr_wdt) begin
                wdtf_r <= 1'b0;
            end
            if (clr_por) begin
                porf_r <= 1'b0;
            end
            if (clr_ext) begin
                extf_r <= 1'b0;
            end
        end
    end

    // Watchdog interrupt held through recovery, raised once core runs
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wdt_pend_r <= 1'b0;
        end else if (go_full) begin
            wdt_pend_r <= 1'b0;
        end else if (wdt_wake & ctrl_r[SHRC_B_WDT_IRQ]) begin
            wdt_pend_r <= 1'b1;
        end else if (evt.wdt_irq_ack) begin
            wdt_pend_r <= 1'b0;
        end
    end
    assign wdt_irq_req = wdt_pend_r & evt.irq_enable &
        (state_r == SHRC_RUN || state_r == SHRC_HALT);

    // Vector pulse marks the first run cycle after any recovery
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            vec_r <= 1'b0;
        end else begin
            vec_r <= rec_done & ~go_full;
        end
    end
    assign vector_fetch = vec_r;
    assign vector_addr_lo = SHRC_VEC_LO;
    assign vector_addr_hi = SHRC_VEC_HI;

    // Power controls decoded straight from the registered mode, control bits and full_r
    always_comb begin
        pwr.osc_en = (state_r != SHRC_STOP);
        pwr.sys_clk_en = (state_r != SHRC_STOP) &&
            (state_r != SHRC_REC_RC);
        pwr.core_run = (state_r == SHRC_RUN);
        pwr.core_rst = (state_r == SHRC_REC_RC) ||
            (state_r == SHRC_REC_SYS);
        pwr.full_rst = pwr.core_rst & full_r;
        pwr.wdt_rc_en = (state_r != SHRC_STOP) ||
            (ctrl_r[SHRC_B_WDT_EN] & ctrl_r[SHRC_B_WDT_STOP]);
        pwr.wdt_run = wdt_live;
        pwr.bor_en = (state_r != SHRC_STOP) ||
            ctrl_r[SHRC_B_BOR_STOP];
        pwr.periph_idle = (state_r == SHRC_STOP) ||
            pwr.core_rst;
    end

    // Oscillator pins driven only while stopped
    assign xin_o = 1'b1;
    assign xout_o = 1'b0;
    assign xin_oe_b = (state_r != SHRC_STOP);
    assign xout_oe_b = (state_r != SHRC_STOP);
    assign mode = state_r;
endmodule

// >>> shrc_monitor.sv
// Assertion checker for the stop/halt recovery control ports
`timescale 1ns/1ps
module shrc_monitor
    import shrc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire shrc_evt_t evt,
    input wire logic [SHRC_NPINS-1:0] port_input_data_reg,
    input wire shrc_pwr_t pwr,
    input wire logic xin_o,
    input wire logic xin_oe_b,
    input wire logic xout_o,
    input wire logic xout_oe_b,
    input wire logic vector_fetch,
    input wire logic [15:0] vector_addr_lo,
    input wire logic [15:0] vector_addr_hi,
    input wire logic wdt_irq_req,
    input wire shrc_state_t mode
);
    logic [6:0] tk_r;
    logic [4:0] sc_r;
    logic hard;
    assign hard = evt.por_bor | evt.ext_reset;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // Shadow counters; a hard reset restarts the design's own count
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b)
            tk_r <= 7'h00;
        else if (mode != SHRC_REC_RC || hard)
            tk_r <= 7'h00;
        else
            tk_r <= tk_r + {6'h00, evt.wdt_rc_tick};
    end
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b)
            sc_r <= 5'h00;
        else
            sc_r <= (mode == SHRC_REC_SYS) ? sc_r + 5'h01 : 5'h00;
    end
    sequence s_done;
        mode == SHRC_REC_SYS ##1 mode == SHRC_RUN;
    endsequence
    AST_STOP_IN: assert property (mode == SHRC_RUN && evt.stop_exec && !hard
        && !evt.wdt_timeout |=> mode == SHRC_STOP) else $error("no stop");
    AST_RC_CNT: assert property (mode == SHRC_REC_RC && evt.wdt_rc_tick
        && !hard |=> mode == ($past(tk_r) == 7'h41 ? SHRC_REC_SYS
        : SHRC_REC_RC)) else $error("rc count off");
    AST_SYS_CNT: assert property (mode == SHRC_REC_SYS && !hard |=>
        mode == ($past(sc_r) == 5'h0F ? SHRC_RUN : SHRC_REC_SYS))
        else $error("sys count off");
    AST_VEC: assert property (s_done |-> vector_fetch &&
        vector_addr_lo == 16'h0002 && vector_addr_hi == 16'h0003
        ##1 !vector_fetch) else $error("vector fetch wrong");
    AST_STOP_PINS: assert property (mode == SHRC_STOP |-> xin_o &&
        !xout_o && !xin_oe_b && !xout_oe_b && !pwr.osc_en && !pwr.sys_clk_en
        && !pwr.core_run && pwr.periph_idle) else $error("stop pins wrong");
    AST_IN_FROZEN: assert property (mode != SHRC_RUN && mode != SHRC_HALT
        && !hard |=> $stable(port_input_data_reg)) else $error("pins sampled");
    AST_HALT_PWR: assert property (mode == SHRC_HALT |-> pwr.osc_en &&
        pwr.sys_clk_en && !pwr.core_run && pwr.wdt_rc_en && !pwr.periph_idle)
        else $error("halt power wrong");
    AST_HALT_OUT: assert property (mode == SHRC_HALT && evt.any_irq &&
        !hard && !evt.wdt_timeout |=> mode == SHRC_RUN) else $error("halt stuck");
    AST_POR_WINS: assert property (evt.por_bor |=> mode == SHRC_REC_RC &&
        pwr.full_rst) else $error("por lost");
    AST_IRQ_GATE: assert property (wdt_irq_req |-> evt.irq_enable &&
        (mode == SHRC_RUN || mode == SHRC_HALT)) else $error("irq ungated");
endmodule
bind shrc_top shrc_monitor u_mon (.core_clk, .rst_b, .evt,
    .port_input_data_reg, .pwr, .xin_o, .xin_oe_b, .xout_o, .xout_oe_b,
    .vector_fetch, .vector_addr_lo, .vector_addr_hi, .wdt_irq_req, .mode);

// >>> shrc_core_model.sv
// Core-side model: issues stop and halt, makes watchdog RC ticks
`timescale 1ns/1ps
module shrc_core_model
    import shrc_pkg::*;
#(
    parameter int unsigned TICK_DIV = 3
)
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic core_run,
    input wire logic [1:0] cmd,
    output logic stop_exec,
    output logic halt_exec,
    output logic rc_tick
);
    logic [7:0] div_r;
    // Instructions retire only while the core runs; crystal clocking only
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            stop_exec <= 1'b0;
            halt_exec <= 1'b0;
        end else begin
            stop_exec <= cmd == 2'h1 && core_run;
            halt_exec <= cmd == 2'h2 && core_run;
        end
    end
    // RC runs free, slower than the core, to stretch the first count
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            div_r <= 8'h00;
            rc_tick <= 1'b0;
        end else begin
            div_r <= (div_r == 8'(TICK_DIV - 1)) ? 8'h00 : div_r + 8'h01;
            rc_tick <= div_r == 8'(TICK_DIV - 1);
        end
    end
endmodule

// >>> tb_stop_halt_recovery_control.sv
// Self-checking bench for the stop/halt recovery control
`timescale 1ns/1ps
module tb_stop_halt_recovery_control
    import shrc_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [2:0] avs_address = 3'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [SHRC_NPINS-1:0] gpio_in = {SHRC_NPINS{1'b0}};
    logic [SHRC_NPINS-1:0] pidr;
    logic [1:0] cmd = 2'h0;
    localparam logic [4:0] P_IRQ = 5'h01;
    localparam logic [4:0] P_WTO = 5'h02;
    localparam logic [4:0] P_POR = 5'h04;
    localparam logic [4:0] P_ACK = 5'h08;
    localparam logic [4:0] P_EXT = 5'h10;
    logic [4:0] pls = 5'h00;
    logic ien = 1'b1;
    logic m_stop, m_halt, m_tick, vf, wirq, pchg;
    shrc_evt_t evt;
    shrc_pwr_t pwr;
    shrc_state_t mode;
    int err_total = 0;
    int cmp_count = 0;
    logic [31:0] q;
    assign evt = {m_stop, m_halt, pls[0], pls[1], pls[2], pls[4], m_tick,
        ien, pls[3]};
    shrc_core_model core (.core_clk, .rst_b, .core_run(pwr.core_run),
        .cmd, .stop_exec(m_stop), .halt_exec(m_halt), .rc_tick(m_tick));
    shrc_top uut (.core_clk, .rst_b, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .evt, .gpio_in,
        .port_input_data_reg(pidr), .pin_change(pchg), .pwr, .xin_o(),
        .xin_oe_b(), .xout_o(), .xout_oe_b(), .vector_fetch(vf),
        .vector_addr_lo(), .vector_addr_hi(), .wdt_irq_req(wirq), .mode);
    initial forever #2 core_clk = ~core_clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [2:0] a,
        input logic [31:0] d);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rchk(input logic [2:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    task automatic cm(input shrc_state_t e);
        #1 chk({29'h0, mode}, {29'h0, e});
    endtask
    task automatic wfetch();
        do @(posedge core_clk); while (vf !== 1'b1);
    endtask
    task automatic op(input logic [1:0] c);
        @(posedge core_clk);
        cmd <= c;
        @(posedge core_clk);
        cmd <= 2'h0;
        repeat (3) @(posedge core_clk);
    endtask
    task automatic pulse(input logic [4:0] m);
        @(posedge core_clk);
        pls <= m;
        @(posedge core_clk);
        pls <= 5'h00;
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Longest legal run is about 1500 cycles; the 40000 ns limit is 10000 cycles
    initial begin
        #40000;
        err_total++;
        summarize();
    end
    initial begin
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        wfetch();
        cm(SHRC_RUN);
        rchk(SHRC_A_WDTCTL, 32'h4);
        rchk(SHRC_A_CTRL, 32'h0);
        rchk(3'h6, 32'h0);
        $display("test reset done");
        acc(1'b1, SHRC_A_CTRL, 32'hF);
        acc(1'b1, SHRC_A_SMRE_LO, 32'h1);
        acc(1'b1, SHRC_A_SMRE_HI, 32'h0800_0000);
        acc(1'b1, SHRC_A_WDTCTL, 32'hF);
        acc(1'b1, 3'h7, 32'hFFFF_FFFF);
        rchk(SHRC_A_WDTCTL, 32'h0);
        rchk(3'h7, 32'h0);
        $display("test registers done");
        op(2'h1);
        cm(SHRC_STOP);
        chk({30'h0, pwr.bor_en, pwr.wdt_run}, 32'h3);
        // Two cycles is under the filter span, so no wake
        @(posedge core_clk);
        gpio_in[0] <= 1'b1;
        repeat (2) @(posedge core_clk);
        gpio_in[0] <= 1'b0;
        repeat (8) @(posedge core_clk);
        cm(SHRC_STOP);
        @(posedge core_clk);
        gpio_in[59] <= 1'b1;
        wfetch();
        #1 chk({31'h0, pchg}, 32'h1);
        rchk(SHRC_A_WDTCTL, 32'h1);
        rchk(SHRC_A_CTRL, 32'hF);
        rchk(SHRC_A_SMRE_HI, 32'h0800_0000);
        chk({30'h0, pidr[59], pidr[0]}, 32'h2);
        acc(1'b1, SHRC_A_WDTCTL, 32'hF);
        $display("test pin wake done");
        op(2'h1);
        pulse(P_WTO);
        wfetch();
        @(posedge core_clk);
        #1 chk({31'h0, wirq}, 32'h1);
        @(posedge core_clk);
        ien <= 1'b0;
        #1 chk({31'h0, wirq}, 32'h0);
        @(posedge core_clk);
        ien <= 1'b1;
        pulse(P_ACK);
        repeat (2) @(posedge core_clk);
        #1 chk({31'h0, wirq}, 32'h0);
        rchk(SHRC_A_WDTCTL, 32'h3);
        $display("test watchdog wake done");
        op(2'h2);
        cm(SHRC_HALT);
        pulse(P_IRQ);
        cm(SHRC_RUN);
        op(2'h2);
        pulse(P_POR);
        cm(SHRC_REC_RC);
        wfetch();
        rchk(SHRC_A_CTRL, 32'h0);
        rchk(SHRC_A_WDTCTL, 32'h4);
        $display("test halt and por done");
        pulse(P_EXT);
        cm(SHRC_REC_RC);
        wfetch();
        rchk(SHRC_A_WDTCTL, 32'h8);
        acc(1'b1, SHRC_A_CTRL, 32'h1);
        op(2'h2);
        cm(SHRC_HALT);
        pulse(P_WTO);
        cm(SHRC_REC_RC);
        wfetch();
        rchk(SHRC_A_WDTCTL, 32'h2);
        $display("test external and watchdog reset done");
        summarize();
    end
endmodule
